// ### pkg/asiu_pkg.sv
package asiu_pkg;
  // register byte addresses
  localparam logic [31:0] off_codec_chan_status = 32'hFFFAC048;
  localparam logic [31:0] off_codec_event_mask = 32'hFFFAC04C;
  localparam logic [31:0] off_global_status = 32'hFFFAC050;
  localparam logic [31:0] off_irq_enable_set = 32'hFFFAC054;
  localparam logic [31:0] off_irq_enable_clear = 32'hFFFAC058;
  localparam logic [31:0] off_irq_enable_view = 32'hFFFAC05C;

  // codec channel status and event mask fields
  localparam int bit_tx_holding_free = 0;
  localparam int bit_tx_fully_drained = 1;
  localparam int bit_tx_starved = 2;
  localparam int bit_rx_word_waiting = 4;
  localparam int bit_rx_overwritten = 5;
  localparam int codec_w = 6;
  localparam logic [5:0] codec_mask_bits = 6'h37;
  localparam logic [5:0] codec_mask_reset = 6'h00;

  // global status, enable and mask fields
  localparam int bit_sof = 0;
  localparam int bit_wake = 1;
  localparam int bit_codec_evt = 2;
  localparam int bit_chan_a_evt = 3;
  localparam int bit_chan_b_evt = 4;
  localparam int gsrc_w = 5;
  localparam logic [4:0] irq_mask_reset = 5'h00;

  // bus answers
  localparam logic [1:0] resp_okay = 2'h0;
  localparam logic [1:0] resp_slverr = 2'h2;
endpackage

// ### core/asiu_top.sv
// Overview of operation
// R1: codec event mask holds five enable bits
// R2: start-of-frame flag set until status read
// R3: wake flag set on serial input rising edge
// R4: reading global status clears frame, wake flags
// R5: codec event is masked codec status nonzero
// R6: channel A event is status AND mode
// R7: channel B event is status AND mode
// R8: channel event flags follow their condition only
// R9: enable-set writes of one enable sources
// R10: enable-clear writes of one disable sources
// R11: mask view shows enabled sources
// R12: interrupt when flag and mask; reset disabled
// R13: overrun sticky, cleared by codec status read
//
// Our own choice: the AXI4-Lite register port.
module asiu_top
  import asiu_pkg::*;
#(
  parameter int ADDR_W = 32,
  parameter int CHAN_W = 32
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write address
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // axi4-lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read address
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // axi4-lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // codec channel logic
  input wire logic tx_holding_free,
  input wire logic tx_fully_drained,
  input wire logic tx_starved_pulse,
  input wire logic rx_word_waiting,
  input wire logic rx_word_load,
  // channels a and b
  input wire logic [CHAN_W-1:0] chan_a_status,
  input wire logic [CHAN_W-1:0] chan_a_mode,
  input wire logic [CHAN_W-1:0] chan_b_status,
  input wire logic [CHAN_W-1:0] chan_b_mode,
  // frame timing and codec line
  input wire logic frame_start,
  input wire logic sdata_in,
  // interrupt
  output logic irq
);

  if (ADDR_W < 8 || ADDR_W > 32) begin : g_chk_addr
    $error("asiu_top: ADDR_W must lie in 8..32");
  end
  if (CHAN_W < 1 || CHAN_W > 32) begin : g_chk_chan
    $error("asiu_top: CHAN_W must lie in 1..32");
  end
  // every field position must lie inside the width the state is built from
  if (codec_w <= bit_rx_overwritten || gsrc_w <= bit_chan_b_evt) begin : g_chk_fields
    $error("asiu_top: field position outside its register width");
  end
  // each register takes one aligned word; the decode compares full byte addresses
  if (off_codec_chan_status[1:0] != 2'h0 || off_codec_event_mask[1:0] != 2'h0 ||
      off_global_status[1:0] != 2'h0 || off_irq_enable_set[1:0] != 2'h0 ||
      off_irq_enable_clear[1:0] != 2'h0 || off_irq_enable_view[1:0] != 2'h0) begin : g_chk_align
    $error("asiu_top: register offsets must be word aligned");
  end

  typedef struct packed {
    logic awready;
    logic wready;
    logic aw_got;
    logic w_got;
    logic [ADDR_W-1:0] waddr;
    logic [31:0] wdata;
    logic wlane0;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [codec_w-1:0] codec_event_mask;
    logic [gsrc_w-1:0] irq_mask;
    logic sof;
    logic wake;
    logic sync1;
    logic sync2;
    logic sync3;
    logic codec_evt;
    logic chan_a_evt;
    logic chan_b_evt;
    logic tx_starved;
    logic rx_overwritten;
    logic irq;
  } asiu_state_type;

  asiu_state_type r;
  asiu_state_type next_r;

  // reset image built at elaboration, so the reset branch loads one constant
  function automatic asiu_state_type reset_value();
    asiu_state_type s;
    s = '0;
    s.awready = 1'b1;
    s.wready = 1'b1;
    s.arready = 1'b1;
    s.codec_event_mask = codec_mask_reset;
    s.irq_mask = irq_mask_reset; // [R12]
    return s;
  endfunction

  localparam asiu_state_type state_at_reset = reset_value();

  // a narrow bus decodes only the low address bits
  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [31:0] off);
    hit = (a == off[ADDR_W-1:0]);
  endfunction

  logic [codec_w-1:0] codec_stat;
  logic [gsrc_w-1:0] gstat;
  logic do_write;
  logic do_read;
  logic rd_gstat;
  logic rd_codec;

  // address decode results and pending sources
  logic wr_cmask;
  logic wr_set;
  logic wr_clr;
  logic wr_ro;
  logic rd_cmask;
  logic rd_view;
  logic rd_wo;
  logic [gsrc_w-1:0] pend;

  always_comb begin
    next_r = r;

    codec_stat = '0;
    codec_stat[bit_tx_holding_free] = tx_holding_free;
    codec_stat[bit_tx_fully_drained] = tx_fully_drained;
    codec_stat[bit_tx_starved] = r.tx_starved;
    codec_stat[bit_rx_word_waiting] = rx_word_waiting;
    codec_stat[bit_rx_overwritten] = r.rx_overwritten;

    gstat = '0;
    gstat[bit_sof] = r.sof;
    gstat[bit_wake] = r.wake;
    gstat[bit_codec_evt] = r.codec_evt;
    gstat[bit_chan_a_evt] = r.chan_a_evt;
    gstat[bit_chan_b_evt] = r.chan_b_evt;

    // one compare per register, shared by the branches below
    wr_cmask = hit(r.waddr, off_codec_event_mask);
    wr_set = hit(r.waddr, off_irq_enable_set);
    wr_clr = hit(r.waddr, off_irq_enable_clear);
    wr_ro = hit(r.waddr, off_global_status) || hit(r.waddr, off_irq_enable_view) ||
            hit(r.waddr, off_codec_chan_status);
    rd_cmask = hit(s_axi_araddr, off_codec_event_mask);
    rd_view = hit(s_axi_araddr, off_irq_enable_view);
    rd_wo = hit(s_axi_araddr, off_irq_enable_set) || hit(s_axi_araddr, off_irq_enable_clear);

    // write channels, taken in either order
    // ready stays low until the answer is taken, so writes never overlap
    if (s_axi_awvalid && r.awready) begin
      next_r.awready = 1'b0;
      next_r.aw_got = 1'b1;
      next_r.waddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && r.wready) begin
      next_r.wready = 1'b0;
      next_r.w_got = 1'b1;
      next_r.wdata = s_axi_wdata;
      next_r.wlane0 = s_axi_wstrb[0];
    end

    do_write = r.aw_got && r.w_got && !r.bvalid;
    if (do_write) begin
      next_r.aw_got = 1'b0;
      next_r.w_got = 1'b0;
      next_r.bvalid = 1'b1;
      next_r.bresp = resp_okay;
      // every field sits in byte lane 0
      if (wr_cmask) begin
        if (r.wlane0) begin
          next_r.codec_event_mask = r.wdata[codec_w-1:0] & codec_mask_bits; // [R1]
        end
      end else if (wr_set) begin
        if (r.wlane0) begin
          next_r.irq_mask = r.irq_mask | r.wdata[gsrc_w-1:0]; // [R9]
        end
      end else if (wr_clr) begin
        if (r.wlane0) begin
          next_r.irq_mask = r.irq_mask & ~r.wdata[gsrc_w-1:0]; // [R10]
        end
      end else if (!wr_ro) begin
        // read-only words answer OKAY and change nothing; the rest are unmapped
        next_r.bresp = resp_slverr;
      end
    end
    if (r.bvalid && s_axi_bready) begin
      next_r.bvalid = 1'b0;
      next_r.awready = 1'b1;
      next_r.wready = 1'b1;
    end

    // read channel, one outstanding
    // rdata is captured at the take, so a flag this read clears still reads 1
    do_read = s_axi_arvalid && r.arready;
    rd_gstat = do_read && hit(s_axi_araddr, off_global_status);
    rd_codec = do_read && hit(s_axi_araddr, off_codec_chan_status);
    if (do_read) begin
      next_r.arready = 1'b0;
      next_r.rvalid = 1'b1;
      next_r.rdata = '0;
      next_r.rresp = resp_okay;
      if (rd_cmask) begin
        next_r.rdata[codec_w-1:0] = r.codec_event_mask; // [R1]
      end else if (rd_gstat) begin
        next_r.rdata[gsrc_w-1:0] = gstat;
      end else if (rd_view) begin
        next_r.rdata[gsrc_w-1:0] = r.irq_mask; // [R11]
      end else if (rd_codec) begin
        next_r.rdata[codec_w-1:0] = codec_stat;
      end else if (!rd_wo) begin
        next_r.rresp = resp_slverr;
      end
    end
    if (r.rvalid && s_axi_rready) begin
      next_r.rvalid = 1'b0;
      next_r.arready = 1'b1;
    end

    // clear on read first, so a same-cycle event still sets
    if (rd_gstat) begin
      next_r.sof = 1'b0; // [R4]
      next_r.wake = 1'b0; // [R4]
    end
    if (frame_start) begin
      next_r.sof = 1'b1; // [R2]
    end

    // sync1 feeds only sync2; edge seen between sync2 and sync3
    // clocked detector: a wake pulse shorter than one clock can be missed
    next_r.sync1 = sdata_in;
    next_r.sync2 = r.sync1;
    next_r.sync3 = r.sync2;
    if (r.sync2 && !r.sync3) begin
      next_r.wake = 1'b1; // [R3]
    end

    // clear first and set after, so an event in the read cycle is kept
    if (rd_codec) begin
      next_r.rx_overwritten = 1'b0; // [R13]
      next_r.tx_starved = 1'b0;
    end
    if (rx_word_load && rx_word_waiting) begin
      next_r.rx_overwritten = 1'b1; // [R13]
    end
    if (tx_starved_pulse) begin
      next_r.tx_starved = 1'b1;
    end

    // level flags, no read side effect
    // registered, so each flag lags its condition by one cycle
    next_r.codec_evt = |(codec_stat & r.codec_event_mask); // [R5] [R8]
    next_r.chan_a_evt = |(chan_a_status & chan_a_mode); // [R6] [R8]
    next_r.chan_b_evt = |(chan_b_status & chan_b_mode); // [R7] [R8]

    // taken from a register, one cycle behind the flags it watches
    pend = gstat & r.irq_mask;
    next_r.irq = |pend; // [R12]
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      r <= state_at_reset; // [R12]
    end else begin
      r <= next_r;
    end
  end

  assign s_axi_awready = r.awready;
  assign s_axi_wready = r.wready;
  assign s_axi_bvalid = r.bvalid;
  assign s_axi_bresp = r.bresp;
  assign s_axi_arready = r.arready;
  assign s_axi_rvalid = r.rvalid;
  assign s_axi_rdata = r.rdata;
  assign s_axi_rresp = r.rresp;
  assign irq = r.irq;

endmodule

// ### dv/asiu_properties.sv
module asiu_properties
  import asiu_pkg::*;
#(
  parameter int ADDR_W = 32
) (
  // clock, reset and register bus
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // frame mark and interrupt
  input wire logic frame_start,
  input wire logic irq
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  logic [4:0] msk;
  wire logic wtk = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  // shadow mask moves one edge before the real one, hence the depth of 2 below
  wire logic wset = wtk && s_axi_wstrb[0] && s_axi_awaddr == off_irq_enable_set[ADDR_W-1:0];
  wire logic wclr = wtk && s_axi_wstrb[0] && s_axi_awaddr == off_irq_enable_clear[ADDR_W-1:0];
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      msk <= 5'h00;
    end else if (wset) begin
      msk <= msk | s_axi_wdata[4:0];
    end else if (wclr) begin
      msk <= msk & ~s_axi_wdata[4:0];
    end
  end
  sequence s_busy; !s_axi_awready ##1 !s_axi_awready; endsequence
  sequence s_quiet; (msk == 5'h00) [*3]; endsequence
  a_bvalid_late: assert property (wtk |-> ##2 s_axi_bvalid)
    else $error("write answer not two cycles after take");
  a_aw_busy: assert property (wtk |=> s_busy)
    else $error("write accepted while busy");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=>
    s_axi_rvalid && !s_axi_arready)
    else $error("read answer missing");
  a_read_free: assert property (s_axi_rvalid && s_axi_rready |=> s_axi_arready)
    else $error("read port not free again");
  a_irq_reset: assert property ($rose(aresetn) |-> !irq)
    else $error("interrupt high out of reset");
  a_irq_quiet: assert property (s_quiet |-> !irq)
    else $error("interrupt with all sources disabled");
  a_irq_cause: assert property ($rose(irq) |-> $past(msk, 2) != 5'h00)
    else $error("interrupt rose with empty mask");
  a_sof_irq: assert property (frame_start && msk[0] |-> ##2 irq)
    else $error("frame start did not raise interrupt");
endmodule
bind asiu_top asiu_properties #(.ADDR_W(ADDR_W)) u_props (.aclk(aclk), .aresetn(aresetn),
  .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .frame_start(frame_start), .irq(irq));

// ### dv/asiu_codec_model.sv
module asiu_codec_model (
  // clock and bench requests
  input wire logic aclk,
  input wire logic go_frame,
  input wire logic go_wake,
  // controller side
  output logic frame_start = 1'h0,
  output logic sdata_in = 1'h0
);
  timeunit 1ns;
  timeprecision 1ns;
  always @(posedge aclk) begin
    frame_start <= go_frame;
    sdata_in <= go_wake;
  end
endmodule

// ### dv/asiu_top_tb.sv
module asiu_top_tb
  import asiu_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic aclk = 1'h0, aresetn = 1'h0, go_frame = 1'h0, go_wake = 1'h0, frame_start, sdata_in;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0, s_axi_awready, irq;
  logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0, s_axi_wready, s_axi_bvalid, s_axi_rvalid;
  logic s_axi_arready, tx_starved_pulse = 1'h0, rx_word_load = 1'h0;
  logic [1:0] s_axi_bresp, s_axi_rresp, rr, rq;
  logic [2:0] lv = 3'h0;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0, s_axi_araddr = 32'h0, s_axi_rdata;
  logic [31:0] chan_a_status = 32'h0, chan_a_mode = 32'h0, chan_b_status = 32'h0;
  logic [31:0] chan_b_mode = 32'h0;
  int failures = 0, n_tests = 0;
  always #50 aclk = ~aclk;
  asiu_top dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awprot(3'h0), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arprot(3'h0),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .tx_holding_free(lv[0]), .tx_fully_drained(lv[1]), .tx_starved_pulse(tx_starved_pulse),
    .rx_word_waiting(lv[2]), .rx_word_load(rx_word_load), .chan_a_status(chan_a_status),
    .chan_a_mode(chan_a_mode), .chan_b_status(chan_b_status), .chan_b_mode(chan_b_mode),
    .frame_start(frame_start), .sdata_in(sdata_in), .irq(irq));
  asiu_codec_model codec (.aclk(aclk), .go_frame(go_frame), .go_wake(go_wake),
    .frame_start(frame_start), .sdata_in(sdata_in));
  task automatic print_verdict;
    $display("checks %0d failures %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] g, e);
    n_tests++;
    if (g !== e) failures++;
    if (g !== e) $display("BAD %s exp %h got %h", n, e, g);
  endtask
  task automatic wr(input logic [31:0] a, v);
    @(posedge aclk);
    {s_axi_awaddr, s_axi_wdata, s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {a, v, 3'h7};
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
    end while (s_axi_awvalid && !s_axi_awready || s_axi_wvalid && !s_axi_wready);
    do @(posedge aclk); while (!s_axi_bvalid);
    s_axi_bready <= 1'h0;
    rr = s_axi_bresp;
  endtask
  task automatic rd(input logic [31:0] a, e, input string n);
    @(posedge aclk);
    {s_axi_araddr, s_axi_arvalid, s_axi_rready} <= {a, 2'h3};
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'h0;
    do @(posedge aclk); while (!s_axi_rvalid);
    s_axi_rready <= 1'h0;
    rq = s_axi_rresp;
    chk(n, s_axi_rdata, e);
  endtask
  task automatic t_regs;
    rd(off_irq_enable_view, 32'h0, "mask_rst");
    rd(off_codec_event_mask, 32'h0, "cmask_rst");
    wr(off_irq_enable_set, 32'h1F);
    wr(off_irq_enable_set, 32'h0);
    wr(off_irq_enable_clear, 32'h0A);
    wr(off_irq_enable_clear, 32'h0);
    rd(off_irq_enable_view, 32'h15, "mask");
    wr(off_irq_enable_clear, 32'h1F);
    wr(off_codec_event_mask, 32'hFFFFFFFF);
    chk("okay_w", rr, resp_okay);
    rd(off_codec_event_mask, 32'h37, "cmask");
    wr(32'hFFFAC060, 32'h1F);
    chk("slverr", rr, resp_slverr);
    rd(off_irq_enable_view, 32'h0, "mask_off");
    rd(32'hFFFAC060, 32'h0, "unmapped");
    chk("slverr_r", rq, resp_slverr);
    rd(off_irq_enable_set, 32'h0, "wo_read");
    chk("okay_r", rq, resp_okay);
    s_axi_wstrb <= 4'hE;
    wr(off_irq_enable_set, 32'h1F);
    s_axi_wstrb <= 4'hF;
    rd(off_irq_enable_view, 32'h0, "lane_off");
    $display("t_regs done");
  endtask
  task automatic t_codec;
    for (int i = 0; i < 3; i++) begin
      lv <= 3'h1 << i;
      rd(off_global_status, 32'h4, "codec_chan_event");
      wr(off_codec_event_mask, 32'h37 ^ (32'h1 << (i + i / 2 * 2)));
      rd(off_global_status, 32'h0, "codec_chan_event_off");
      wr(off_codec_event_mask, 32'h37);
    end
    {lv, rx_word_load, tx_starved_pulse} <= 5'h13;
    @(posedge aclk);
    {lv, rx_word_load, tx_starved_pulse} <= 5'h00;
    rd(off_codec_chan_status, 32'h24, "sticky");
    rd(off_codec_chan_status, 32'h0, "sticky_clr");
    $display("t_codec done");
  endtask
  task automatic t_chan;
    {chan_a_status, chan_a_mode} <= {32'hF0, 32'h1F};
    {chan_b_status, chan_b_mode} <= {32'h80000000, 32'h7FFFFFFF};
    wr(off_irq_enable_set, 32'h08);
    rd(off_global_status, 32'h08, "chan_a");
    rd(off_global_status, 32'h08, "keep");
    chk("irq_on", irq, 32'h1);
    {chan_a_mode, chan_b_mode} <= {32'h0F, 32'hFFFFFFFF};
    repeat (3) @(posedge aclk);
    chk("irq_drop", irq, 32'h0);
    rd(off_global_status, 32'h10, "chan_b");
    chan_b_mode <= 32'h0;
    wr(off_irq_enable_clear, 32'h1F);
    $display("t_chan done");
  endtask
  task automatic t_sw;
    wr(off_irq_enable_set, 32'h03);
    {go_frame, go_wake} <= 2'h3;
    @(posedge aclk);
    go_frame <= 1'h0;
    repeat (8) @(posedge aclk);
    chk("irq_sw", irq, 32'h1);
    rd(off_global_status, 32'h03, "sof_wake");
    rd(off_global_status, 32'h00, "rd_clr");
    chk("irq_clr", irq, 32'h0);
    go_wake <= 1'h0;
    $display("t_sw done");
  endtask
  task automatic t_reset;
    wr(off_irq_enable_set, 32'h1F);
    aresetn <= 1'h0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'h1;
    chk("irq_rst", irq, 32'h0);
    rd(off_irq_enable_view, 32'h0, "mask_rst2");
    $display("t_reset done");
  endtask
  initial begin
    repeat (3) @(posedge aclk);
    aresetn <= 1'h1;
    t_regs;
    t_codec;
    t_chan;
    t_sw;
    t_reset;
    print_verdict;
  end
  // a hung handshake ends the run well after the expected few hundred cycles
  initial begin
    repeat (4000) @(posedge aclk);
    failures++;
    print_verdict;
  end
endmodule
